// >>> tca_alarm.sv
`timescale 1ns/10ps
// Behaviour
// - 32 outputs, each optionally a channel alarm
// - enabled alarm drives line from options
// - configs kept in storage, reloaded at power-up
// - settings apply on change and power-on
// - evaluate alarms regardless of host link
// - two thresholds, two hysteresis directions
// - window mode: below first or above second
// - reading-only mode ignores errors
// - combined mode: threshold, open or cmv
// - error-only mode ignores thresholds
// - disabled alarm leaves host digital output
// - active-low mode pulls line low
// - active-high mode releases line high
// - latched alarm holds until host clear
// - alarm led on for any alarm
// - open-circuit led on for any open
// - identify blinks power led five times
// - activity on with link, blinks per command
// - upgrade mode blinks power and activity
// - open reported within one second
// - temperature updates at most three per second; every converter sample is taken, rate set by the converter
// - software selects 50 or 60 hz filter
// - measurements compared as 32-bit floats
module tca_alarm
   import tca_pkg::*;
#(
   parameter int BLINK_HALF = TCA_BLINK_HALF_CYC,
   parameter int ACT_OFF = TCA_ACT_OFF_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter sample strobe and value
   input wire logic samp_valid,
   input wire logic [4:0] samp_chan,
   input wire logic [31:0] samp_temp,
   // non-volatile store read port
   output logic nv_rd,
   output logic [6:0] nv_addr,
   input wire logic nv_ack,
   input wire logic [31:0] nv_data,
   input wire logic nv_valid,
   // open-drain outputs, pin level and enable
   input wire logic [31:0] dout_in,
   output logic [31:0] dout_out,
   output logic [31:0] dout_oe,
   // indicators and filter select
   output logic alarm_led,
   output logic open_circuit_indicator,
   output logic power_led,
   output logic activity_led,
   output logic filter_60hz
);
   // per-channel storage
   logic [TCA_CFG_W-1:0] cfg [TCA_NCH];
   logic [31:0] thr1 [TCA_NCH];
   logic [31:0] thr2 [TCA_NCH];
   logic [31:0] temp [TCA_NCH];
   logic [31:0] ctrl; // control bits
   logic [31:0] dout_reg; // host digital output value
   logic [31:0] open_flags; // open status per channel
   logic [31:0] cm_flags; // common-mode error per channel
   logic [31:0] latched; // latched alarms
   logic [4:0] sel; // channel window for cfg/threshold access
   logic [31:0] upd; // one-cycle sample strobe per channel
   wire logic [31:0] raw; // unlatched channel alarms
   tca_boot_t boot;
   logic [6:0] boot_idx; // store word walker
   logic boot_ok; // store was valid

   // apb decode
   wire logic wr_en = psel && penable && pwrite;
   wire logic rd_en = psel && penable && !pwrite;
   wire logic booting = (boot != TCA_BOOT_RUN);
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit
   wire logic known = hit(paddr, TCA_OFF_CTRL) || hit(paddr, TCA_OFF_STAT)
      || hit(paddr, TCA_OFF_DOUT) || hit(paddr, TCA_OFF_CLR)
      || hit(paddr, TCA_OFF_OPEN) || hit(paddr, TCA_OFF_CMERR)
      || hit(paddr, TCA_OFF_ALARM) || hit(paddr, TCA_OFF_SEL)
      || hit(paddr, TCA_OFF_CFG) || hit(paddr, TCA_OFF_THR1)
      || hit(paddr, TCA_OFF_THR2) || hit(paddr, TCA_OFF_TEMP)
      || hit(paddr, TCA_OFF_NVSTAT);
   // commands from host arrive as control writes
   wire logic cmd_wr = wr_en && hit(paddr, TCA_OFF_CTRL);
   wire logic clr_wr = wr_en && hit(paddr, TCA_OFF_CLR);
   wire logic [31:0] clr_mask = clr_wr ? pwdata : 32'h0;

   // answer in the first access cycle; unmapped gets an error
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
      end
   end

   // read mux, registered for the access cycle
   logic [31:0] next_rd;
   always_comb begin
      next_rd = 32'h0;
      case (paddr)
         TCA_OFF_CTRL: next_rd = ctrl;
         TCA_OFF_STAT: next_rd = {30'h0, boot_ok, booting};
         TCA_OFF_DOUT: next_rd = dout_reg;
         TCA_OFF_CLR: next_rd = dout_in;
         TCA_OFF_OPEN: next_rd = open_flags;
         TCA_OFF_CMERR: next_rd = cm_flags;
         TCA_OFF_ALARM: next_rd = raw | latched;
         TCA_OFF_SEL: next_rd = {27'h0, sel};
         TCA_OFF_CFG: next_rd = {25'h0, cfg[sel]};
         TCA_OFF_THR1: next_rd = thr1[sel];
         TCA_OFF_THR2: next_rd = thr2[sel];
         TCA_OFF_TEMP: next_rd = temp[sel];
         TCA_OFF_NVSTAT: next_rd = {25'h0, boot_idx};
         default: next_rd = 32'h0;
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= next_rd;
   end

   // control and scalar registers; host can write these while booting
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= 32'h0;
         dout_reg <= TCA_DOUT_RST;
         open_flags <= 32'h0;
         cm_flags <= 32'h0;
         sel <= 5'h0;
      end else if (wr_en) begin
         if (hit(paddr, TCA_OFF_CTRL)) ctrl <= pwdata &
            ((32'h1 << TCA_CTRL_FILT60) | (32'h1 << TCA_CTRL_LINK)
            | (32'h1 << TCA_CTRL_UPGRADE));
         if (hit(paddr, TCA_OFF_DOUT)) dout_reg <= pwdata;
         if (hit(paddr, TCA_OFF_OPEN)) open_flags <= pwdata;
         if (hit(paddr, TCA_OFF_CMERR)) cm_flags <= pwdata;
         if (hit(paddr, TCA_OFF_SEL)) sel <= pwdata[4:0];
      end
   end

   // open flags pass straight to the alarm path
   // converter writes temperature; rate set by the converter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) upd <= 32'h0;
      else upd <= samp_valid ? (32'h1 << samp_chan) : 32'h0;
   end

   // boot walk: three words per channel from the store
   wire logic [4:0] boot_ch = boot_idx[6:2];
   wire logic [1:0] boot_w = boot_idx[1:0];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         boot <= TCA_BOOT_REQ;
         boot_idx <= 7'h0;
         boot_ok <= 1'b0;
         nv_rd <= 1'b0;
         nv_addr <= 7'h0;
      end else begin
         nv_rd <= 1'b0;
         case (boot)
            TCA_BOOT_REQ: begin
               nv_rd <= 1'b1;
               nv_addr <= boot_idx;
               boot <= TCA_BOOT_WAIT;
            end
            TCA_BOOT_WAIT: if (nv_ack) begin
               // invalid store stops load, cfg stays disabled
               if (!nv_valid) boot <= TCA_BOOT_RUN;
               else if (boot_idx == 7'h7e) begin
                  boot_ok <= 1'b1;
                  boot <= TCA_BOOT_RUN;
               end else begin
                  boot_idx <= (boot_w == 2'h2) ?
                     {boot_ch + 5'h1, 2'h0} : boot_idx + 7'h1;
                  boot <= TCA_BOOT_REQ;
               end
            end
            TCA_BOOT_RUN: boot <= TCA_BOOT_RUN;
            default: boot <= TCA_BOOT_REQ;
         endcase
      end
   end
   wire logic boot_load = (boot == TCA_BOOT_WAIT) && nv_ack && nv_valid;

   // channel arrays; generate per channel
   genvar g;
   generate
      for (g = 0; g < TCA_NCH; g++) begin : gch
         wire logic here = (sel == 5'(g));
         wire logic bhere = boot_load && (boot_ch == 5'(g));
         // writes take effect the next cycle
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               cfg[g] <= TCA_CFG_RST;
               thr1[g] <= 32'h0;
               thr2[g] <= 32'h0;
            end else if (bhere) begin
               if (boot_w == 2'h0) cfg[g] <= nv_data[TCA_CFG_W-1:0];
               if (boot_w == 2'h1) thr1[g] <= nv_data;
               if (boot_w == 2'h2) thr2[g] <= nv_data;
            end else if (wr_en && here && !booting) begin
               if (hit(paddr, TCA_OFF_CFG))
                  cfg[g] <= pwdata[TCA_CFG_W-1:0];
               if (hit(paddr, TCA_OFF_THR1)) thr1[g] <= pwdata;
               if (hit(paddr, TCA_OFF_THR2)) thr2[g] <= pwdata;
            end
         end
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) temp[g] <= 32'h0;
            else if (samp_valid && samp_chan == 5'(g)) temp[g] <= samp_temp;
         end
         // evaluation runs with no host involvement
         tca_chan u_ch (
            .mclk(mclk),
            .rst(rst),
            .upd(upd[g]),
            .temp(temp[g]),
            .thr1(thr1[g]),
            .thr2(thr2[g]),
            .in_mode(cfg[g][TCA_CFG_IN_LSB +: 2]),
            .err_mode(cfg[g][TCA_CFG_ERR_LSB +: 2]),
            .broken(open_flags[g]),
            .cm_err(cm_flags[g]),
            .alarm(raw[g])
         );
         wire logic [1:0] om = cfg[g][TCA_CFG_OUT_LSB +: 2];
         wire logic en = (om == TCA_OUT_LOW) || (om == TCA_OUT_HIGH);
         // latch holds; new alarm wins over clear
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) latched[g] <= 1'b0;
            else if (raw[g] && cfg[g][TCA_CFG_LATCH] && en)
               latched[g] <= 1'b1;
            else if (clr_mask[g] || !cfg[g][TCA_CFG_LATCH])
               latched[g] <= 1'b0;
         end
         wire logic act = raw[g] || latched[g];
         wire logic lvl = (om == TCA_OUT_LOW) ? !act :
            (om == TCA_OUT_HIGH) ? act : dout_reg[g];
         // open drain: enable means pull low
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               dout_out[g] <= 1'b0;
               dout_oe[g] <= 1'b0;
            end else begin
               dout_out[g] <= 1'b0;
               dout_oe[g] <= !lvl;
            end
         end
      end
   endgenerate

   // indicators
   logic [31:0] bcnt; // blink half-period counter
   logic [3:0] bleft; // half-periods left of identify blink
   logic [31:0] acnt; // activity off-time counter
   logic upph; // upgrade blink phase
   wire logic bdone = (bcnt == 32'(BLINK_HALF - 1));
   // free half-period tick
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) bcnt <= 32'h0;
      else bcnt <= bdone ? 32'h0 : bcnt + 32'h1;
   end
   wire logic blink_cmd = cmd_wr && pwdata[TCA_CTRL_BLINK];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) bleft <= 4'h0;
      else if (blink_cmd) bleft <= 4'(2 * TCA_BLINK_COUNT);
      else if (bdone && bleft != 4'h0) bleft <= bleft - 4'h1;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) upph <= 1'b0;
      else if (bdone) upph <= !upph;
   end
   wire logic cmd_seen = cmd_wr && pwdata[TCA_CTRL_CMD];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) acnt <= 32'h0;
      else if (cmd_seen) acnt <= 32'(ACT_OFF);
      else if (acnt != 32'h0) acnt <= acnt - 32'h1;
   end
   wire logic upg = ctrl[TCA_CTRL_UPGRADE];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         alarm_led <= 1'b0;
         open_circuit_indicator <= 1'b0;
         power_led <= 1'b0;
         activity_led <= 1'b0;
         filter_60hz <= 1'b0;
      end else begin
         alarm_led <= |(raw | latched);
         open_circuit_indicator <= |open_flags;
         power_led <= upg ? upph : (bleft == 4'h0) || !bleft[0];
         activity_led <= upg ? upph :
            ctrl[TCA_CTRL_LINK] && (acnt == 32'h0);
         filter_60hz <= ctrl[TCA_CTRL_FILT60];
      end
   end
endmodule : tca_alarm

// >>> tca_pkg.sv
package tca_pkg;
   // channel count and data width
   localparam int TCA_NCH = 32;
   localparam int TCA_DW = 32;
   // register byte offsets
   localparam logic [11:0] TCA_OFF_CTRL = 12'h000;
   localparam logic [11:0] TCA_OFF_STAT = 12'h004;
   localparam logic [11:0] TCA_OFF_DOUT = 12'h008;
   localparam logic [11:0] TCA_OFF_CLR = 12'h00c;
   localparam logic [11:0] TCA_OFF_OPEN = 12'h010;
   localparam logic [11:0] TCA_OFF_CMERR = 12'h014;
   localparam logic [11:0] TCA_OFF_ALARM = 12'h018;
   localparam logic [11:0] TCA_OFF_SEL = 12'h01c;
   localparam logic [11:0] TCA_OFF_CFG = 12'h020;
   localparam logic [11:0] TCA_OFF_THR1 = 12'h024;
   localparam logic [11:0] TCA_OFF_THR2 = 12'h028;
   localparam logic [11:0] TCA_OFF_TEMP = 12'h02c;
   localparam logic [11:0] TCA_OFF_NVSTAT = 12'h030;
   // control register bit positions
   localparam int TCA_CTRL_FILT60 = 0;
   localparam int TCA_CTRL_LINK = 1;
   localparam int TCA_CTRL_CMD = 2;
   localparam int TCA_CTRL_BLINK = 3;
   localparam int TCA_CTRL_UPGRADE = 4;
   // per-channel config field positions
   localparam int TCA_CFG_IN_LSB = 0;
   localparam int TCA_CFG_ERR_LSB = 2;
   localparam int TCA_CFG_OUT_LSB = 4;
   localparam int TCA_CFG_LATCH = 6;
   localparam int TCA_CFG_W = 7;
   // reset values
   localparam logic [TCA_CFG_W-1:0] TCA_CFG_RST = 7'h00;
   localparam logic [31:0] TCA_DOUT_RST = 32'hffffffff;
   // timing, 250 MHz clock
   localparam int TCA_CLK_MHZ = 250;
   localparam int TCA_BLINK_HALF_MS = 250;
   localparam int TCA_BLINK_HALF_CYC = TCA_BLINK_HALF_MS * 1000 * TCA_CLK_MHZ;
   localparam int TCA_ACT_OFF_MS = 50;
   localparam int TCA_ACT_OFF_CYC = TCA_ACT_OFF_MS * 1000 * TCA_CLK_MHZ;
   localparam int TCA_BLINK_COUNT = 5;
   // input, error and output modes
   typedef enum logic [1:0] {
      TCA_IN_HIGH = 2'h0, TCA_IN_LOW = 2'h1, TCA_IN_WINDOW = 2'h2
   } tca_in_t;
   typedef enum logic [1:0] {
      TCA_ERR_TEMP = 2'h0, TCA_ERR_ALL = 2'h1, TCA_ERR_ONLY = 2'h2
   } tca_err_t;
   typedef enum logic [1:0] {
      TCA_OUT_OFF = 2'h0, TCA_OUT_LOW = 2'h1, TCA_OUT_HIGH = 2'h2
   } tca_out_t;
   // boot loader states, gray along the path
   typedef enum logic [1:0] {
      TCA_BOOT_REQ = 2'h0, TCA_BOOT_WAIT = 2'h1, TCA_BOOT_RUN = 2'h3
   } tca_boot_t;
endpackage : tca_pkg

// >>> tca_fcmp.sv
`timescale 1ns/10ps
// ieee single compare, a below b; nan never compares
module tca_fcmp (
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   output logic lt,
   output logic eq
);
   // magnitude keys with sign folded in
   wire logic a_nan = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
   wire logic b_nan = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
   wire logic both_zero = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
   wire logic [31:0] ka = a[31] ? ~a : {1'b1, a[30:0]};
   wire logic [31:0] kb = b[31] ? ~b : {1'b1, b[30:0]};
   // zero of either sign is equal
   assign eq = !a_nan && !b_nan && (both_zero || (a == b));
   assign lt = !a_nan && !b_nan && !both_zero && (ka < kb);
endmodule : tca_fcmp

// >>> tca_chan.sv
`timescale 1ns/10ps
// one channel: comparison, hysteresis, error mode
module tca_chan
   import tca_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic upd,
   input wire logic [31:0] temp,
   input wire logic [31:0] thr1,
   input wire logic [31:0] thr2,
   input wire logic [1:0] in_mode,
   input wire logic [1:0] err_mode,
   input wire logic broken,
   input wire logic cm_err,
   output logic alarm
);
   logic trip; // threshold state, held between updates
   wire logic lt1, eq1, lt2, eq2;
   tca_fcmp u_c1 (.a(temp), .b(thr1), .lt(lt1), .eq(eq1));
   tca_fcmp u_c2 (.a(temp), .b(thr2), .lt(lt2), .eq(eq2));
   wire logic gt2 = !lt2 && !eq2 && (temp[30:23] != 8'hff || temp[22:0] == 0);
   wire logic ge1 = !lt1 && (temp[30:23] != 8'hff || temp[22:0] == 0);
   wire logic set_hi = ge1;
   wire logic clr_hi = lt2;
   wire logic set_lo = lt1 || eq1;
   wire logic clr_lo = gt2;
   wire logic win = lt1 || gt2;
   logic next_trip;
   // hold state between set and reset; window mode follows win directly
   always_comb begin
      next_trip = trip;
      case (in_mode)
         TCA_IN_HIGH: if (set_hi) next_trip = 1'b1;
            else if (clr_hi) next_trip = 1'b0;
         TCA_IN_LOW: if (set_lo) next_trip = 1'b1;
            else if (clr_lo) next_trip = 1'b0;
         TCA_IN_WINDOW: next_trip = win;
         default: next_trip = 1'b0;
      endcase
   end
   // threshold state only moves on a fresh sample
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) trip <= 1'b0;
      else if (upd) trip <= next_trip;
   end
   always_comb begin
      case (err_mode)
         TCA_ERR_TEMP: alarm = trip;
         TCA_ERR_ALL: alarm = trip || broken || cm_err;
         TCA_ERR_ONLY: alarm = broken || cm_err;
         default: alarm = 1'b0;
      endcase
   end
endmodule : tca_chan

// >>> tca_alarm_chk.sv
`timescale 1ns/10ps
// port-level watch on the alarm block
module tca_alarm_chk
   import tca_pkg::*;
#(
   parameter int BLINK_HALF = 4,
   parameter int ACT_OFF = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic nv_rd,
   input wire logic [6:0] nv_addr,
   input wire logic [31:0] dout_out,
   input wire logic power_led,
   input wire logic activity_led,
   input wire logic open_circuit_indicator,
   input wire logic filter_60hz
);
   // completed write, one per transfer
   wire wr_done = psel && penable && pready && pwrite;
   wire ctrl_wr = wr_done && (paddr == TCA_OFF_CTRL);
   wire open_wr = wr_done && (paddr == TCA_OFF_OPEN) && (pwdata != 32'h0);
   wire filt_bit = pwdata[TCA_CTRL_FILT60];
   wire cmd_wr = ctrl_wr && pwdata[TCA_CTRL_LINK] && pwdata[TCA_CTRL_CMD];
   wire id_wr = ctrl_wr && pwdata[TCA_CTRL_BLINK];
   wire upg_wr = ctrl_wr && pwdata[TCA_CTRL_UPGRADE];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   AST_APB_READY: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   AST_ERR_QUAL: assert property (pslverr |->
      pready && (pwrite || prdata == 32'h0))
      else $error("error without ready or with read data");
   AST_OD_SINK_ONLY: assert property (dout_out == 32'h0)
      else $error("open-drain line driven high");
   AST_NV_RANGE: assert property (nv_rd |-> nv_addr <= 7'h7e)
      else $error("store address past last word");
   AST_NV_PULSE: assert property (nv_rd |=> !nv_rd)
      else $error("store read not a pulse");
   AST_OPEN_LED: assert property (open_wr |->
      ##[1:2] open_circuit_indicator)
      else $error("open indicator not lit");
   AST_FILTER: assert property (ctrl_wr |=>
      ##1 filter_60hz == $past(filt_bit, 2))
      else $error("filter select not applied");
   AST_ACT_DIP: assert property (cmd_wr |-> ##[1:4] !activity_led)
      else $error("activity did not dip on command");
   AST_ID_BLINK: assert property (id_wr |-> ##[1:12] !power_led)
      else $error("power did not start blinking");
   AST_UPG_BLINK: assert property (upg_wr |-> ##[1:12] !activity_led)
      else $error("activity not blinking in upgrade");

   // main scenarios reached
   cover property (cmd_wr);
   cover property (open_wr);
   cover property (pslverr);
endmodule : tca_alarm_chk

// >>> tca_nv_model.sv
`timescale 1ns/10ps
// non-volatile store answering the boot loader
module tca_nv_model #(
   parameter int LAT = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic nv_rd,
   input wire logic [6:0] nv_addr,
   input wire logic good,
   output logic nv_ack,
   output logic [31:0] nv_data,
   output logic nv_valid
);
   logic [6:0] adr; // captured word address
   int cnt; // wait before answer, LAT sets speed

   // stored setup: only the top channel carries one
   function automatic logic [31:0] word(input logic [6:0] a);
      if (a[6:2] != 5'h1f) return 32'h00000000;
      case (a[1:0])
         2'h0: return 32'h00000010;
         2'h1: return 32'h41a00000;
         default: return 32'h41200000;
      endcase
   endfunction : word

   // answer after a delay; bad store flags words invalid
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         adr <= 7'h00;
         nv_ack <= 1'b0;
         nv_valid <= 1'b0;
         nv_data <= 32'h0;
      end else begin
         nv_ack <= 1'b0;
         // stale data is scrambled, never left standing
         if (nv_ack) {nv_valid, nv_data} <= ~{nv_valid, nv_data};
         if (nv_rd) begin
            adr <= nv_addr;
            cnt <= LAT;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               nv_ack <= 1'b1;
               nv_valid <= good;
               nv_data <= word(adr);
            end
         end
      end
   end
endmodule : tca_nv_model

// >>> thermocouple_alarm_outputs_tb.sv
`timescale 1ns/10ps
module thermocouple_alarm_outputs_tb;
   import tca_pkg::*;
   // float temperatures
   localparam logic [31:0] F5 = 32'h40a00000;
   localparam logic [31:0] F10 = 32'h41200000;
   localparam logic [31:0] F15 = 32'h41700000;
   localparam logic [31:0] F20 = 32'h41a00000;
   localparam logic [31:0] F30 = 32'h41f00000;
   typedef struct packed {
      logic [6:0] cfg;
      logic [31:0] t1, t2, tmp;
      logic op, cm, oe;
   } tca_row_t;
   // row index is the channel, so each starts clear
   tca_row_t rows [15] = '{
      '{7'h10, F20, F10, F20, 1'b0, 1'b0, 1'b1},
      '{7'h10, F20, F10, F10, 1'b0, 1'b0, 1'b0},
      '{7'h11, F10, F20, F10, 1'b0, 1'b0, 1'b1},
      '{7'h11, F10, F20, F30, 1'b0, 1'b0, 1'b0},
      '{7'h12, F10, F20, F5, 1'b0, 1'b0, 1'b1},
      '{7'h12, F10, F20, F30, 1'b0, 1'b0, 1'b1},
      '{7'h12, F10, F20, F20, 1'b0, 1'b0, 1'b0},
      '{7'h10, F20, F10, F5, 1'b1, 1'b0, 1'b0},
      '{7'h14, F20, F10, F5, 1'b1, 1'b0, 1'b1},
      '{7'h14, F20, F10, F5, 1'b0, 1'b1, 1'b1},
      '{7'h18, F20, F10, F30, 1'b0, 1'b0, 1'b0},
      '{7'h18, F20, F10, F5, 1'b0, 1'b1, 1'b1},
      '{7'h20, F20, F10, F30, 1'b0, 1'b0, 1'b0},
      '{7'h20, F20, F10, F5, 1'b0, 1'b0, 1'b1},
      '{7'h00, F20, F10, F30, 1'b0, 1'b0, 1'b0}};
   tca_row_t r;
   logic mclk = 1'b0, rst = 1'b1, nv_good = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, samp_temp = 32'h0, q, prdata, nv_data;
   logic samp_valid = 1'b0, e, pready, pslverr, nv_rd, nv_ack, nv_valid;
   logic [4:0] samp_chan = 5'h00;
   logic [6:0] nv_addr;
   logic [31:0] dout_out, dout_oe;
   logic alarm_led, open_circuit_indicator, power_led, activity_led;
   logic filter_60hz, pwr_q = 1'b0, act_q = 1'b0;
   int error_cnt = 0, checks_done = 0, pwr_falls = 0, act_falls = 0, pb, ab;
   // pull-up pins: low only where enabled
   wire logic [31:0] dout_in = ~dout_oe;

   always #2 mclk = ~mclk;

   tca_alarm #(.BLINK_HALF(4), .ACT_OFF(3)) tca_alarm_inst (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .samp_valid(samp_valid),
      .samp_chan(samp_chan), .samp_temp(samp_temp), .nv_rd(nv_rd),
      .nv_addr(nv_addr), .nv_ack(nv_ack), .nv_data(nv_data),
      .nv_valid(nv_valid), .dout_in(dout_in), .dout_out(dout_out),
      .dout_oe(dout_oe), .alarm_led(alarm_led),
      .open_circuit_indicator(open_circuit_indicator),
      .power_led(power_led), .activity_led(activity_led),
      .filter_60hz(filter_60hz));
   tca_nv_model #(.LAT(3)) tca_nv_model_inst (
      .mclk(mclk), .rst(rst), .nv_rd(nv_rd), .nv_addr(nv_addr),
      .good(nv_good), .nv_ack(nv_ack), .nv_data(nv_data),
      .nv_valid(nv_valid));

   // count led turn-offs for blink checks
   always @(posedge mclk) begin
      pwr_q <= power_led;
      act_q <= activity_led;
      if (pwr_q && !power_led) pwr_falls <= pwr_falls + 1;
      if (act_q && !activity_led) act_falls <= act_falls + 1;
   end

   task automatic results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chkw

   task automatic chk1(input logic got, input logic exp);
      chkw({31'h0, got}, {31'h0, exp});
   endtask : chk1

   // one apb transfer, held until ready, then an idle edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic cfg_ch(input logic [4:0] c, input logic [6:0] m,
                         input logic [31:0] a, input logic [31:0] b);
      wr(TCA_OFF_SEL, {27'h0, c});
      wr(TCA_OFF_CFG, {25'h0, m});
      wr(TCA_OFF_THR1, a);
      wr(TCA_OFF_THR2, b);
   endtask : cfg_ch

   // one converter sample, then outputs settle
   task automatic samp(input logic [4:0] c, input logic [31:0] t);
      samp_valid <= 1'b1;
      samp_chan <= c;
      samp_temp <= t;
      @(posedge mclk);
      samp_valid <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : samp

   task automatic boot_wait;
      apb(1'b0, TCA_OFF_STAT, 32'h0);
      while (q[0] !== 1'b0) begin
         apb(1'b0, TCA_OFF_STAT, 32'h0);
      end
   endtask : boot_wait

   // hang guard, well past the expected 1200 or so cycles
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      results();
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      boot_wait();
      chkw({30'h0, q[1:0]}, 32'h2);
      samp(5'h1f, F30);
      chk1(dout_oe[31], 1'b1);
      wr(TCA_OFF_CTRL, 32'h3);
      repeat (2) @(posedge mclk);
      chk1(filter_60hz, 1'b1);
      chk1(activity_led, 1'b1);
      for (int i = 0; i < 15; i++) begin
         r = rows[i];
         cfg_ch(5'(i), r.cfg, r.t1, r.t2);
         wr(TCA_OFF_OPEN, 32'(r.op) << i);
         wr(TCA_OFF_CMERR, 32'(r.cm) << i);
         samp(5'(i), r.tmp);
         chk1(dout_oe[i], r.oe);
         chk1(open_circuit_indicator, r.op);
      end
      chk1(alarm_led, 1'b1);
      cfg_ch(5'h11, 7'h10, F20, F10);
      samp(5'h11, F30);
      chk1(dout_oe[17], 1'b1);
      samp(5'h11, F15);
      chk1(dout_oe[17], 1'b1);
      samp(5'h11, F5);
      chk1(dout_oe[17], 1'b0);
      cfg_ch(5'h10, 7'h50, F20, F10);
      samp(5'h10, F30);
      samp(5'h10, F5);
      chk1(dout_oe[16], 1'b1);
      apb(1'b0, TCA_OFF_ALARM, 32'h0);
      chk1(q[16], 1'b1);
      wr(TCA_OFF_CLR, 32'h00010000);
      repeat (2) @(posedge mclk);
      chk1(dout_oe[16], 1'b0);
      wr(TCA_OFF_DOUT, 32'hffffbfff);
      repeat (2) @(posedge mclk);
      chk1(dout_oe[14], 1'b1);
      apb(1'b0, TCA_OFF_CLR, 32'h0);
      chk1(q[14], 1'b0);
      apb(1'b0, 12'h100, 32'h0);
      chk1(e, 1'b1);
      chkw(q, 32'h0);
      ab = act_falls;
      wr(TCA_OFF_CTRL, 32'h7);
      repeat (12) @(posedge mclk);
      chkw(32'(act_falls - ab), 32'h1);
      chk1(activity_led, 1'b1);
      pb = pwr_falls;
      wr(TCA_OFF_CTRL, 32'hb);
      repeat (60) @(posedge mclk);
      chkw(32'(pwr_falls - pb), 32'h5);
      chk1(power_led, 1'b1);
      pb = pwr_falls;
      ab = act_falls;
      wr(TCA_OFF_CTRL, 32'h13);
      repeat (30) @(posedge mclk);
      chk1(pwr_falls > pb && act_falls > ab, 1'b1);
      nv_good <= 1'b0;
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      boot_wait();
      chkw({30'h0, q[1:0]}, 32'h0);
      samp(5'h1f, F30);
      chk1(dout_oe[31], 1'b0);
      results();
   end
endmodule : thermocouple_alarm_outputs_tb

bind tca_alarm tca_alarm_chk #(.BLINK_HALF(BLINK_HALF), .ACT_OFF(ACT_OFF))
   tca_alarm_chk_inst (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_rd(nv_rd),
   .nv_addr(nv_addr), .dout_out(dout_out), .power_led(power_led),
   .activity_led(activity_led),
   .open_circuit_indicator(open_circuit_indicator),
   .filter_60hz(filter_60hz));
